// file: logic/peiu_event_latch.sv
`timescale 1ns/100ps

module peiu_event_latch (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [15:0] evt_vec,
    input wire logic [15:0] clear_mask,
    output logic [15:0] pending
);

    typedef struct packed {
        logic [15:0] pending;
    } peiu_latch_state_t;

    peiu_latch_state_t state;
    peiu_latch_state_t next_state;

    // A new event is ORed in after the clear, so an event that coincides
    // with the clearing read survives for the next read.
    always_comb
    begin
        next_state = state;
        next_state.pending = ((state.pending & ~clear_mask) | evt_vec)
            & peiu_pkg::EVENT_MASK;
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state.pending <= peiu_pkg::PENDING_RESET;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign pending = state.pending;

endmodule

// file: logic/peiu_irq_drive.sv
`timescale 1ns/100ps

module peiu_irq_drive (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [15:0] pending,
    input wire logic [15:0] enable,
    input wire logic polarity_low,
    output logic irq_active,
    output logic irq_pin
);

    typedef struct packed {
        logic active;
        logic pin;
    } peiu_irq_state_t;

    peiu_irq_state_t state;
    peiu_irq_state_t next_state;
    logic request;

    always_comb
    begin
        next_state = state;
        request = |(pending & enable);
        next_state.active = request;
        next_state.pin = polarity_low ? ~request : request;
    end

    // The pin resets to its idle level for the default active-low polarity.
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state.active <= 1'h0;
            state.pin <= 1'h1;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign irq_active = state.active;
    assign irq_pin = state.pin;

endmodule

// file: logic/peiu_pkg.sv
package peiu_pkg;

    // Register port geometry.
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;

    // Register offsets on the management register port.
    localparam logic [4:0] ENABLE_OFS = 5'h12;
    localparam logic [4:0] PENDING_OFS = 5'h13;
    localparam logic [4:0] CONFIG_OFS = 5'h14;

    // Event positions, shared by the enable and the pending register.
    localparam int NEG_ERROR_POS = 15;
    localparam int RATE_CHANGE_POS = 14;
    localparam int DUPLEX_CHANGE_POS = 13;
    localparam int PAGE_RECEIVED_POS = 12;
    localparam int NEG_DONE_POS = 11;
    localparam int LINK_CHANGE_POS = 10;
    localparam int FALSE_CARRIER_POS = 8;
    localparam int PAIR_SWAP_POS = 6;
    localparam int RATE_DOWNSHIFT_POS = 5;
    localparam int DOZE_CHANGE_POS = 4;
    localparam int WAKE_PACKET_POS = 3;
    localparam int MAC_SIDE_ERROR_POS = 2;
    localparam int POLARITY_FLIP_POS = 1;
    localparam int JABBER_POS = 0;

    // Bits 9 and 7 carry no event in either register.
    localparam logic [15:0] EVENT_MASK = 16'hFD7F;

    // Position of the interrupt pin polarity bit in the configuration register.
    localparam int IRQ_POLARITY_POS = 13;

    // Reset values.
    localparam logic [15:0] ENABLE_RESET = 16'h0000;
    localparam logic [15:0] PENDING_RESET = 16'h0000;
    localparam logic IRQ_POLARITY_RESET = 1'h1;

endpackage

// file: logic/phy_event_interrupt_unit.sv
// Overview of operation
// - Interrupt only for enabled event that occurred
// - Status bit sets even when not enabled
// - Status bit shows event since last read
// - Read returning one clears that status bit
// - Bit 15 negotiation error, bit 11 done
// - Bit 14 rate change, bit 13 duplex
// - Bit 12 page received, clear on read
// - Bit 10 link change, bit 8 carrier
// - Bit 6 pair swap, bit 1 polarity
// - Bit 5 downshift, bit 4 doze change
// - Bit 3 wake packet, bit 2 MAC error
// - Bit 0 jabber, latched, clear on read
// - Config bit 13 sets pin polarity, default low
//
// Our own choice: the strobed register port.
`timescale 1ns/100ps

module phy_event_interrupt_unit (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic evt_negotiation_error,
    input wire logic evt_rate_change,
    input wire logic evt_duplex_change,
    input wire logic evt_page_received,
    input wire logic evt_negotiation_done,
    input wire logic evt_link_change,
    input wire logic evt_false_carrier,
    input wire logic evt_pair_swap_change,
    input wire logic evt_rate_downshift,
    input wire logic evt_doze_change,
    input wire logic evt_wake_packet,
    input wire logic evt_mac_side_error,
    input wire logic evt_polarity_flip,
    input wire logic evt_jabber,
    output logic irq_pin
);

    typedef struct packed {
        logic [15:0] enable;
        logic polarity_low;
        logic [15:0] rdata;
    } peiu_top_state_t;

    peiu_top_state_t state;
    peiu_top_state_t next_state;

    logic [15:0] evt_vec;
    logic [15:0] pending;
    logic [15:0] clear_mask;
    logic irq_active;
    logic read_pending;

    function automatic logic hits(input logic strobe, input logic [4:0] addr,
                                  input logic [4:0] ofs);
        hits = strobe && (addr == ofs);
    endfunction

    // Event sources come from detection logic on the same clock, so no
    // synchroniser is needed; each is a one-cycle occurrence strobe.
    always_comb
    begin
        evt_vec = 16'h0000;
        evt_vec[peiu_pkg::NEG_ERROR_POS] = evt_negotiation_error;
        evt_vec[peiu_pkg::NEG_DONE_POS] = evt_negotiation_done;
        evt_vec[peiu_pkg::RATE_CHANGE_POS] = evt_rate_change;
        evt_vec[peiu_pkg::DUPLEX_CHANGE_POS] = evt_duplex_change;
        evt_vec[peiu_pkg::PAGE_RECEIVED_POS] = evt_page_received;
        evt_vec[peiu_pkg::LINK_CHANGE_POS] = evt_link_change;
        evt_vec[peiu_pkg::FALSE_CARRIER_POS] = evt_false_carrier;
        evt_vec[peiu_pkg::PAIR_SWAP_POS] = evt_pair_swap_change;
        evt_vec[peiu_pkg::POLARITY_FLIP_POS] = evt_polarity_flip;
        evt_vec[peiu_pkg::RATE_DOWNSHIFT_POS] = evt_rate_downshift;
        evt_vec[peiu_pkg::DOZE_CHANGE_POS] = evt_doze_change;
        evt_vec[peiu_pkg::WAKE_PACKET_POS] = evt_wake_packet;
        evt_vec[peiu_pkg::MAC_SIDE_ERROR_POS] = evt_mac_side_error;
        evt_vec[peiu_pkg::JABBER_POS] = evt_jabber;
    end

    // Only the bits that the read actually returns as one are cleared, which
    // keeps each pending event reported exactly once.
    assign read_pending = hits(reg_rd, reg_addr, peiu_pkg::PENDING_OFS);
    assign clear_mask = read_pending ? pending : 16'h0000;

    peiu_event_latch u_latch (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .evt_vec(evt_vec),
        .clear_mask(clear_mask),
        .pending(pending)
    );

    peiu_irq_drive u_irq (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .pending(pending),
        .enable(state.enable),
        .polarity_low(state.polarity_low),
        .irq_active(irq_active),
        .irq_pin(irq_pin)
    );

    // Register port. Read data stand for one cycle after the read strobe and
    // are zero at all other times, so a stale word is never mistaken for a
    // fresh one. Unmapped offsets read zero and ignore writes.
    always_comb
    begin
        next_state = state;
        next_state.rdata = 16'h0000;
        if (hits(reg_wr, reg_addr, peiu_pkg::ENABLE_OFS))
        begin
            next_state.enable = reg_wdata & peiu_pkg::EVENT_MASK;
        end
        if (hits(reg_wr, reg_addr, peiu_pkg::CONFIG_OFS))
        begin
            next_state.polarity_low = reg_wdata[peiu_pkg::IRQ_POLARITY_POS];
        end
        if (reg_rd)
        begin
            case (reg_addr)
                peiu_pkg::ENABLE_OFS:
                begin
                    next_state.rdata = state.enable;
                end
                peiu_pkg::PENDING_OFS:
                begin
                    next_state.rdata = pending;
                end
                peiu_pkg::CONFIG_OFS:
                begin
                    next_state.rdata[peiu_pkg::IRQ_POLARITY_POS] = state.polarity_low;
                end
                default:
                begin
                    next_state.rdata = 16'h0000;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state.enable <= peiu_pkg::ENABLE_RESET;
            state.polarity_low <= peiu_pkg::IRQ_POLARITY_RESET;
            state.rdata <= 16'h0000;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign reg_rdata = state.rdata;

    default clocking cb @(posedge core_clk);
    endclocking

    default disable iff (!arst_n);

    a_status_latches: assert property (
        (|evt_vec) |=> ((pending & $past(evt_vec)) == $past(evt_vec))
    ) else $error("An event did not latch its status bit.");

    a_status_holds: assert property (
        (!read_pending && (pending != 16'h0000))
        |=> ((pending & $past(pending)) == $past(pending))
    ) else $error("A pending bit dropped without a read.");

    a_no_spurious_set: assert property (
        (evt_vec == 16'h0000) |=> ((pending & ~$past(pending)) == 16'h0000)
    ) else $error("A pending bit set with no event.");

    a_read_returns: assert property (
        read_pending |=> (reg_rdata == $past(pending))
    ) else $error("Pending read did not return the latched events.");

    a_read_clears: assert property (
        read_pending
        |=> ((pending & $past(pending) & ~$past(evt_vec)) == 16'h0000)
    ) else $error("Read did not clear the bits it returned.");

    a_set_beats_clear: assert property (
        (read_pending && (|evt_vec))
        |=> ((pending & $past(evt_vec)) == $past(evt_vec))
    ) else $error("Event lost during a clearing read.");

    a_reported_once: assert property (
        (read_pending && !evt_negotiation_error
         && pending[peiu_pkg::NEG_ERROR_POS])
        ##1 (reg_rd && (reg_addr == peiu_pkg::PENDING_OFS)
             && !$past(evt_negotiation_error))
        |=> (reg_rdata[peiu_pkg::NEG_ERROR_POS] == 1'h0)
    ) else $error("A pending event was reported twice.");

    // Each mapping check ties each strobe to its own bit, so two positions that
    // were swapped are caught when one of the two events arrives alone.
    a_map_upper: assert property (
        (evt_negotiation_error || evt_negotiation_done)
        |=> (pending[15] || !$past(evt_negotiation_error))
            && (pending[11] || !$past(evt_negotiation_done))
    ) else $error("Negotiation events latched at the wrong bits.");

    a_map_rate: assert property (
        evt_rate_change |=> pending[14]
    ) else $error("Rate change latched at the wrong bit.");

    a_map_duplex: assert property (
        evt_duplex_change |=> pending[13]
    ) else $error("Duplex change latched at the wrong bit.");

    a_map_page: assert property (
        evt_page_received |=> pending[12]
    ) else $error("Page received latched at the wrong bit.");

    a_map_link: assert property (
        (evt_link_change || evt_false_carrier)
        |=> (pending[10] || !$past(evt_link_change))
            && (pending[8] || !$past(evt_false_carrier))
    ) else $error("Link or carrier event latched at the wrong bit.");

    a_map_pairs: assert property (
        (evt_pair_swap_change || evt_polarity_flip)
        |=> (pending[6] || !$past(evt_pair_swap_change))
            && (pending[1] || !$past(evt_polarity_flip))
    ) else $error("Pair swap or polarity latched at the wrong bit.");

    a_map_doze: assert property (
        (evt_rate_downshift || evt_doze_change)
        |=> (pending[5] || !$past(evt_rate_downshift))
            && (pending[4] || !$past(evt_doze_change))
    ) else $error("Downshift or doze latched at the wrong bit.");

    a_map_wake: assert property (
        (evt_wake_packet || evt_mac_side_error)
        |=> (pending[3] || !$past(evt_wake_packet))
            && (pending[2] || !$past(evt_mac_side_error))
    ) else $error("Wake or MAC error latched at the wrong bit.");

    a_map_jabber: assert property (
        evt_jabber |=> pending[0]
    ) else $error("Jabber latched at the wrong bit.");

    a_reserved_zero: assert property (
        (pending[9] == 1'h0) && (pending[7] == 1'h0)
        && (state.enable[9] == 1'h0) && (state.enable[7] == 1'h0)
    ) else $error("A reserved bit became set.");

    a_enable_write: assert property (
        hits(reg_wr, reg_addr, peiu_pkg::ENABLE_OFS)
        |=> (state.enable == ($past(reg_wdata) & peiu_pkg::EVENT_MASK))
    ) else $error("Enable register did not take the written value.");

    a_irq_follows: assert property (
        (|(pending & state.enable)) |=> irq_active
    ) else $error("Enabled pending event did not raise the interrupt.");

    a_irq_needs_enable: assert property (
        irq_active |-> (|($past(pending) & $past(state.enable)))
    ) else $error("Interrupt raised without an enabled pending event.");

    a_irq_masked: assert property (
        (state.enable == 16'h0000) [*2] |-> !irq_active
    ) else $error("Interrupt raised while every event was disabled.");

    a_pin_polarity: assert property (
        ##1 (irq_pin == ($past(state.polarity_low) ? !irq_active : irq_active))
    ) else $error("Interrupt pin polarity does not match the configuration.");

    a_rdata_idle: assert property (
        !reg_rd |=> (reg_rdata == 16'h0000)
    ) else $error("Read data present without a read strobe.");

    a_irq_drops: assert property (
        !(|(pending & state.enable)) |=> !irq_active
    ) else $error("Interrupt stayed up with no enabled pending event.");

    a_no_irq_disabled: assert property (
        ((pending & state.enable) == 16'h0000)
        && ((evt_vec & state.enable) == 16'h0000)
        && !(reg_wr && (reg_addr == peiu_pkg::ENABLE_OFS))
        |=> ##1 !irq_active
    ) else $error("Interrupt raised by a disabled event.");

    a_irq_after_read: assert property (
        (read_pending && (evt_vec == 16'h0000))
        |=> ##1 !irq_active
    ) else $error("Interrupt stayed up after the pending bits were read.");

    a_read_leaves_new: assert property (
        read_pending |=> (pending == $past(evt_vec))
    ) else $error("Pending bits after a read differ from the new events.");

    // Register port checks. Expected words are built from the stored state,
    // not from the read multiplexer, so a wrong select shows up as a mismatch.
    a_enable_holds: assert property (
        !(reg_wr && (reg_addr == peiu_pkg::ENABLE_OFS)) |=> $stable(state.enable)
    ) else $error("Enable register changed without a write.");

    a_polarity_write: assert property (
        (reg_wr && (reg_addr == peiu_pkg::CONFIG_OFS))
        |=> (state.polarity_low == $past(reg_wdata[13]))
    ) else $error("Polarity bit did not take the written value.");

    a_polarity_holds: assert property (
        !(reg_wr && (reg_addr == peiu_pkg::CONFIG_OFS)) |=> $stable(state.polarity_low)
    ) else $error("Polarity bit changed without a write.");

    a_read_enable: assert property (
        (reg_rd && (reg_addr == peiu_pkg::ENABLE_OFS))
        |=> (reg_rdata == $past(state.enable))
    ) else $error("Enable read returned the wrong word.");

    a_read_config: assert property (
        (reg_rd && (reg_addr == peiu_pkg::CONFIG_OFS))
        |=> (reg_rdata == {2'h0, $past(state.polarity_low), 13'h0000})
    ) else $error("Configuration read returned the wrong word.");

    a_other_read_keeps: assert property (
        (reg_rd && (reg_addr != peiu_pkg::PENDING_OFS) && (evt_vec == 16'h0000))
        |=> (pending == $past(pending))
    ) else $error("A read of another register disturbed the pending bits.");

    a_pending_write_ignored: assert property (
        (reg_wr && !reg_rd && (evt_vec == 16'h0000))
        |=> (pending == $past(pending))
    ) else $error("A write disturbed the pending bits.");

    a_unmapped_read: assert property (
        (reg_rd && (reg_addr != peiu_pkg::ENABLE_OFS) && (reg_addr != peiu_pkg::PENDING_OFS)
         && (reg_addr != peiu_pkg::CONFIG_OFS))
        |=> (reg_rdata == 16'h0000)
    ) else $error("An unmapped offset returned data.");

    a_reserved_rdata: assert property (
        reg_rd |=> ((reg_rdata[9] == 1'h0) && (reg_rdata[7] == 1'h0))
    ) else $error("A read returned a reserved bit as one.");

endmodule

// file: sim/peiu_host_model.sv
`timescale 1ns/100ps

module peiu_host_model (
    input wire logic core_clk,
    input wire logic irq_pin,
    input wire logic polarity_low,
    input wire logic [15:0] reg_rdata,
    output logic [4:0] reg_addr,
    output logic [15:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    output logic irq_seen
);
    // The host decodes the pin through the polarity it has programmed.
    assign irq_seen = polarity_low ? ~irq_pin : irq_pin;

    initial
    begin
        reg_addr = 5'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        // Stale write data must never look valid once the strobe has gone.
        reg_wdata <= ~d;
    endtask

    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        // Read data stand for one cycle only, so take them mid-cycle.
        @(negedge core_clk);
        d = reg_rdata;
    endtask

    task automatic rd2(input logic [4:0] a, output logic [15:0] d0, output logic [15:0] d1);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        // The strobe stays up so that a second read follows with no gap.
        @(posedge core_clk);
        @(negedge core_clk);
        d0 = reg_rdata;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        d1 = reg_rdata;
    endtask
endmodule

// file: sim/phy_event_interrupt_unit_tb.sv
`timescale 1ns/100ps

module phy_event_interrupt_unit_tb;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [15:0] evt = 16'h0000;
    logic pol_low = 1'b1;
    logic [4:0] reg_addr;
    logic [15:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [15:0] reg_rdata;
    logic irq_pin;
    logic irq_seen;
    int n_fail = 0;
    int check_count = 0;
    int cycles = 0;
    int pos_tab[14] = '{15, 14, 13, 12, 11, 10, 8, 6, 5, 4, 3, 2, 1, 0};

    always #20 core_clk = ~core_clk;

    phy_event_interrupt_unit u_dut (
        .core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .evt_negotiation_error(evt[15]), .evt_rate_change(evt[14]),
        .evt_duplex_change(evt[13]), .evt_page_received(evt[12]),
        .evt_negotiation_done(evt[11]), .evt_link_change(evt[10]),
        .evt_false_carrier(evt[8]), .evt_pair_swap_change(evt[6]),
        .evt_rate_downshift(evt[5]), .evt_doze_change(evt[4]),
        .evt_wake_packet(evt[3]), .evt_mac_side_error(evt[2]),
        .evt_polarity_flip(evt[1]), .evt_jabber(evt[0]), .irq_pin(irq_pin)
    );

    peiu_host_model u_host (
        .core_clk(core_clk), .irq_pin(irq_pin), .polarity_low(pol_low),
        .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .irq_seen(irq_seen)
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic pulse(input logic [15:0] m);
        @(posedge core_clk);
        evt <= m;
        @(posedge core_clk);
        evt <= 16'h0000;
    endtask

    task automatic settle(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    task automatic t_reset();
        logic [15:0] v;
        check({15'h0000, irq_pin}, 16'h0001);
        u_host.rd(peiu_pkg::ENABLE_OFS, v);
        check(v, 16'h0000);
        u_host.rd(peiu_pkg::PENDING_OFS, v);
        check(v, 16'h0000);
        u_host.rd(peiu_pkg::CONFIG_OFS, v);
        check(v, 16'h2000);
    endtask

    task automatic t_regs();
        logic [15:0] v;
        u_host.wr(peiu_pkg::ENABLE_OFS, 16'hFFFF);
        u_host.rd(peiu_pkg::ENABLE_OFS, v);
        check(v, 16'hFD7F);
        check({15'h0000, irq_seen}, 16'h0000);
        u_host.wr(peiu_pkg::PENDING_OFS, 16'hFFFF);
        u_host.rd(peiu_pkg::PENDING_OFS, v);
        check(v, 16'h0000);
        u_host.rd(5'h1F, v);
        check(v, 16'h0000);
        u_host.wr(5'h1F, 16'h0000);
        u_host.rd(peiu_pkg::ENABLE_OFS, v);
        check(v, 16'hFD7F);
    endtask

    task automatic t_each_event();
        logic [15:0] v;
        logic [15:0] m;
        for (int i = 0; i < 14; i++)
        begin
            m = 16'h0001 << pos_tab[i];
            u_host.wr(peiu_pkg::ENABLE_OFS, ~m);
            pulse(m);
            settle(3);
            check({15'h0000, irq_seen}, 16'h0000);
            u_host.rd(peiu_pkg::PENDING_OFS, v);
            check(v, m);
            u_host.rd(peiu_pkg::PENDING_OFS, v);
            check(v, 16'h0000);
            u_host.wr(peiu_pkg::ENABLE_OFS, m);
            pulse(m);
            settle(2);
            check({15'h0000, irq_seen}, 16'h0001);
            u_host.rd(peiu_pkg::PENDING_OFS, v);
            check(v, m);
            settle(1);
            check({15'h0000, irq_seen}, 16'h0000);
        end
    endtask

    task automatic t_collision();
        logic [15:0] v;
        u_host.wr(peiu_pkg::ENABLE_OFS, 16'h0000);
        pulse(16'h0400);
        // The second event lands in the very cycle of the clearing read.
        fork
            u_host.rd(peiu_pkg::PENDING_OFS, v);
            pulse(16'h0400);
        join
        check(v, 16'h0400);
        u_host.rd(peiu_pkg::PENDING_OFS, v);
        check(v, 16'h0400);
        u_host.rd(peiu_pkg::PENDING_OFS, v);
        check(v, 16'h0000);
    endtask

    task automatic t_burst();
        logic [15:0] v0;
        logic [15:0] v1;
        u_host.wr(peiu_pkg::ENABLE_OFS, 16'hFFFF);
        pulse(16'hFFFF);
        settle(2);
        check({15'h0000, irq_seen}, 16'h0001);
        // Two reads with no gap: the second must not report the same events.
        u_host.rd2(peiu_pkg::PENDING_OFS, v0, v1);
        check(v0, 16'hFD7F);
        check(v1, 16'h0000);
        check({15'h0000, irq_seen}, 16'h0000);
    endtask

    task automatic t_mid_reset();
        u_host.wr(peiu_pkg::CONFIG_OFS, 16'h0000);
        pol_low = 1'b0;
        u_host.wr(peiu_pkg::ENABLE_OFS, 16'h0400);
        pulse(16'h0400);
        settle(2);
        check({15'h0000, irq_pin}, 16'h0001);
        @(posedge core_clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        pol_low = 1'b1;
        @(posedge core_clk);
        t_reset();
    endtask

    task automatic t_polarity();
        logic [15:0] v;
        u_host.wr(peiu_pkg::CONFIG_OFS, 16'h0000);
        pol_low = 1'b0;
        settle(2);
        check({15'h0000, irq_pin}, 16'h0000);
        u_host.wr(peiu_pkg::ENABLE_OFS, 16'h0001);
        pulse(16'h0001);
        settle(2);
        check({15'h0000, irq_pin}, 16'h0001);
        u_host.rd(peiu_pkg::PENDING_OFS, v);
        check(v, 16'h0001);
        settle(1);
        check({15'h0000, irq_pin}, 16'h0000);
        u_host.wr(peiu_pkg::CONFIG_OFS, 16'hFFFF);
        pol_low = 1'b1;
        u_host.rd(peiu_pkg::CONFIG_OFS, v);
        check(v, 16'h2000);
    endtask

    task automatic results();
        $display("Checks made: %0d, mismatches: %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Whole run needs well under a thousand cycles; the margin covers a stuck read.
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_fail++;
            results();
        end
    end

    initial
    begin
        repeat (8) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        t_reset();
        t_regs();
        t_each_event();
        t_collision();
        t_burst();
        t_polarity();
        t_mid_reset();
        results();
    end
endmodule
